//--- rotate_core.sv
// Purpose: Combinational rotate result
// Assumes: Operand and flag valid in the same cycle
// Notes:   Unknown codes write nothing
`timescale 1ns/1ps
`default_nettype none
`include "rotate_unit_defines.svh"
module rotate_core (
	input  wire logic                        i_valid,
	input  wire logic [`ROT_OP_W-1:0]        i_op,
	input  wire logic [`ROT_DATA_W-1:0]      i_data,
	input  wire logic                        i_flag,
	output logic      [`ROT_DATA_W-1:0]      o_data,
	output logic                             o_flag,
	output logic                             o_flag_we,
	output logic                             o_mem_we,
	output logic                             o_wr_we
);
	wire [`ROT_DATA_W-1:0] lc_val;
	wire [`ROT_DATA_W-1:0] r_val;
	wire [`ROT_DATA_W-1:0] rc_val;
	wire is_lc;
	wire is_r;
	wire is_rc;
	assign lc_val = {i_data[`ROT_MSB-1:0], i_flag};
	assign r_val  = {i_data[`ROT_LSB], i_data[`ROT_MSB:1]};
	assign rc_val = {i_flag, i_data[`ROT_MSB:1]};
	assign is_lc = (i_op == `ROT_OP_LC) || (i_op == `ROT_OP_LC_WR);
	assign is_r  = (i_op == `ROT_OP_R) || (i_op == `ROT_OP_R_WR);
	assign is_rc = (i_op == `ROT_OP_RC) || (i_op == `ROT_OP_RC_WR);
	assign o_data = is_lc ? lc_val : (is_r ? r_val : rc_val);
	// Left takes old bit 7, right takes old bit 0
	assign o_flag = is_lc ? i_data[`ROT_MSB] : i_data[`ROT_LSB];
	assign o_flag_we = i_valid && (is_lc || is_rc);
	assign o_mem_we  = i_valid && ((i_op == `ROT_OP_LC) ||
		(i_op == `ROT_OP_R) || (i_op == `ROT_OP_RC));
	assign o_wr_we   = i_valid && ((i_op == `ROT_OP_LC_WR) ||
		(i_op == `ROT_OP_R_WR) || (i_op == `ROT_OP_RC_WR));
endmodule
`default_nettype wire

//--- rotate_unit.sv
// Purpose: Rotate unit of an 8-bit core datapath
// Assumes: Request held one machine cycle, same clock
// Notes:   Result registered, seen by next instruction
// Function
// - Left through flag: old flag to bit 0, bit 7 to flag, to memory.
// - Left through flag result goes to work register, flag updated.
// - Plain right rotate, bit 0 to bit 7, to memory, flag kept.
// - Plain right rotate result to work register, flag kept.
// - Right through flag: old flag to bit 7, bit 0 to flag, to memory.
// - Right through flag result to work register, flag updated.
// - Work register variants never write the memory byte.
`timescale 1ns/1ps
`default_nettype none
`include "rotate_unit_defines.svh"
module rotate_unit (
	input  wire logic                        i_sys_clk,
	input  wire logic                        i_nrst,
	input  wire rotate_unit_pkg::rot_req_type i_req,
	output logic      [`ROT_DATA_W-1:0]      o_mem_wdata,
	output logic                             o_mem_we,
	output logic      [`ROT_DATA_W-1:0]      o_work_reg,
	output logic                             o_flag
);
	rotate_unit_pkg::rot_res_type res;
	logic [`ROT_DATA_W-1:0] mem_wdata_r;
	logic                   mem_we_r;
	logic [`ROT_DATA_W-1:0] work_reg_r;
	logic                   flag_r;
	logic [`ROT_DATA_W-1:0] work_reg_nxt;
	logic                   flag_nxt;
	rotate_core u_core (
		.i_valid   (i_req.valid),
		.i_op      (i_req.op),
		.i_data    (i_req.mem_data),
		.i_flag    (i_req.flag),
		.o_data    (res.data),
		.o_flag    (res.flag),
		.o_flag_we (res.flag_we),
		.o_mem_we  (res.mem_we),
		.o_wr_we   (res.wr_we)
	);
	// Flag holds its own value unless a carry variant runs
	assign flag_nxt     = res.flag_we ? res.flag : flag_r;
	assign work_reg_nxt = res.wr_we ? res.data : work_reg_r;
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			mem_wdata_r <= `ROT_RESET_BYTE;
			mem_we_r    <= 1'b0;
			work_reg_r  <= `ROT_RESET_BYTE;
			flag_r      <= 1'b0;
		end else begin
			mem_wdata_r <= res.data;
			mem_we_r    <= res.mem_we;
			work_reg_r  <= work_reg_nxt;
			flag_r      <= flag_nxt;
		end
	end
	assign o_mem_wdata = mem_wdata_r;
	assign o_mem_we    = mem_we_r;
	assign o_work_reg  = work_reg_r;
	assign o_flag      = flag_r;
	a_left_carry_mem: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_req.valid && i_req.op == `ROT_OP_LC) |=>
		(o_mem_we && o_mem_wdata == {$past(i_req.mem_data[6:0]),
		$past(i_req.flag)} && o_flag == $past(i_req.mem_data[7])))
		else $error("left carry rotate wrong");
	a_left_carry_wr: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_req.valid && i_req.op == `ROT_OP_LC_WR) |=>
		(o_work_reg == {$past(i_req.mem_data[6:0]), $past(i_req.flag)}
		&& o_flag == $past(i_req.mem_data[7])))
		else $error("left carry to work register wrong");
	a_right_mem_flag: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_req.valid && i_req.op == `ROT_OP_R) |=>
		(o_mem_we && o_mem_wdata == {$past(i_req.mem_data[0]),
		$past(i_req.mem_data[7:1])} && $stable(o_flag)))
		else $error("right rotate wrong");
	a_right_wr_flag: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_req.valid && i_req.op == `ROT_OP_R_WR) |=>
		(o_work_reg == {$past(i_req.mem_data[0]),
		$past(i_req.mem_data[7:1])} && $stable(o_flag)))
		else $error("right rotate to work register wrong");
	a_right_carry_mem: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_req.valid && i_req.op == `ROT_OP_RC) |=>
		(o_mem_we && o_mem_wdata == {$past(i_req.flag),
		$past(i_req.mem_data[7:1])} && o_flag == $past(i_req.mem_data[0])))
		else $error("right carry rotate wrong");
	a_right_carry_wr: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_req.valid && i_req.op == `ROT_OP_RC_WR) |=>
		(o_work_reg == {$past(i_req.flag), $past(i_req.mem_data[7:1])}
		&& o_flag == $past(i_req.mem_data[0])))
		else $error("right carry to work register wrong");
	a_wr_no_mem: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_req.valid && (i_req.op == `ROT_OP_LC_WR ||
		i_req.op == `ROT_OP_R_WR || i_req.op == `ROT_OP_RC_WR))
		|=> !o_mem_we)
		else $error("memory written by work register variant");
	a_mem_keeps_wr: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		o_mem_we |-> $stable(o_work_reg))
		else $error("work register changed on memory variant");
	a_one_cycle_we: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(!i_req.valid) |=> !o_mem_we)
		else $error("memory write without request");
endmodule
`default_nettype wire

//--- rotate_unit_defines.svh
// Purpose: Constants for the rotate unit
// Assumes: 8-bit data path
// Notes:   Opcode codes are local choices
`ifndef ROTATE_UNIT_DEFINES_SVH
`define ROTATE_UNIT_DEFINES_SVH
`define ROT_DATA_W      8
`define ROT_MSB         7
`define ROT_LSB         0
`define ROT_OP_W        3
`define ROT_OP_NONE     3'h0
`define ROT_OP_LC       3'h1
`define ROT_OP_LC_WR    3'h2
`define ROT_OP_R        3'h3
`define ROT_OP_R_WR     3'h4
`define ROT_OP_RC       3'h5
`define ROT_OP_RC_WR    3'h6
`define ROT_RESET_BYTE  8'h00
`endif

//--- rotate_unit_pkg.sv
// Purpose: Types for the rotate unit
// Assumes: rotate_unit_defines.svh included
// Notes:   Request and result travel as structs
`include "rotate_unit_defines.svh"
package rotate_unit_pkg;
	typedef struct packed {
		logic                       valid;
		logic [`ROT_OP_W-1:0]       op;
		logic [`ROT_DATA_W-1:0]     mem_data;
		logic                       flag;
	} rot_req_type;
	typedef struct packed {
		logic [`ROT_DATA_W-1:0]     data;
		logic                       flag;
		logic                       flag_we;
		logic                       mem_we;
		logic                       wr_we;
	} rot_res_type;
endpackage

//--- rotate_unit_test.sv
// Purpose: Self-checking bench for the rotate unit
// Assumes: Flag input driven by the bench, not looped back
// Notes:   Rows run back to back, one per machine cycle
`timescale 1ns/1ps
`default_nettype none
`include "rotate_unit_defines.svh"
module rotate_unit_test;
	logic                         clk = 1'h0;
	logic                         nrst = 1'h0;
	rotate_unit_pkg::rot_req_type req = '0;
	logic [`ROT_DATA_W-1:0]       mem_wdata;
	logic                         mem_we;
	logic [`ROT_DATA_W-1:0]       work_reg;
	logic                         flag;
	logic [7:0]                   exp_wr;
	int                           n_mismatch = 0;
	int                           num_checks = 0;
	int                           cyc = 0;
	// Mem rows first, then work register rows; flag kept across plain ops
	logic [2:0] r_op [6] = '{`ROT_OP_LC, `ROT_OP_R, `ROT_OP_RC,
		`ROT_OP_R_WR, `ROT_OP_LC_WR, `ROT_OP_RC_WR};
	logic [7:0] r_in [6] = '{8'h81, 8'h01, 8'h81, 8'h03, 8'h20, 8'h02};
	logic       r_fi [6] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1};
	logic [7:0] r_res [6] = '{8'h02, 8'h80, 8'h40, 8'h81, 8'h41, 8'h81};
	logic       r_fo [6] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0};
	// Refused: op none, op 7, valid low with a live code
	logic [3:0] rc [3] = '{4'h8, 4'hF, 4'h1};
	rotate_unit i_dut (
		.i_sys_clk   (clk),
		.i_nrst      (nrst),
		.i_req       (req),
		.o_mem_wdata (mem_wdata),
		.o_mem_we    (mem_we),
		.o_work_reg  (work_reg),
		.o_flag      (flag)
	);
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task automatic drive(input logic v, input logic [2:0] op,
		input logic [7:0] d, input logic f);
		req = '{v, op, d, f};
	endtask
	task automatic step;
		@(posedge clk);
		#1;
	endtask
	task automatic chk_all(input logic [7:0] w, input logic [7:0] r,
		input logic f);
		chk("mem_we", w, {7'h00, mem_we});
		chk("work_reg", r, work_reg);
		chk("flag", {7'h00, f}, {7'h00, flag});
	endtask
	task automatic wrap_up;
		if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Whole run needs about 32 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 400) begin
			n_mismatch++;
			wrap_up();
		end
	end
	initial begin
		repeat (20) step();
		chk("mem_wdata", 8'h00, mem_wdata);
		chk_all(8'h00, 8'h00, 1'h0);
		nrst = 1'h1;
		exp_wr = 8'h00;
		for (int i = 0; i < 6; i++) begin
			drive(1'h1, r_op[i], r_in[i], r_fi[i]);
			step();
			if (i > 2) exp_wr = r_res[i];
			if (i < 3) chk("mem_wdata", r_res[i], mem_wdata);
			chk_all({7'h00, i < 3}, exp_wr, r_fo[i]);
		end
		drive(1'h1, `ROT_OP_R, 8'h02, 1'h1);
		step();
		chk("mem_wdata", 8'h01, mem_wdata);
		chk_all(8'h01, 8'h81, 1'h0);
		// Wrongly taken refusals would set the flag from 8'hFF
		for (int j = 0; j < 3; j++) begin
			drive(rc[j][3], rc[j][2:0], 8'hFF, 1'h1);
			step();
			chk_all(8'h00, 8'h81, 1'h0);
		end
		nrst = 1'h0;
		drive(1'h1, `ROT_OP_RC_WR, 8'h01, 1'h0);
		step();
		chk_all(8'h00, 8'h00, 1'h0);
		nrst = 1'h1;
		step();
		chk_all(8'h00, 8'h00, 1'h1);
		wrap_up();
	end
endmodule
`default_nettype wire
